// ### adcq_top.sv
// Contract
// - a gain-stage conversion started singly by software or event gives a wrong result.
// - the event output pulses on every completed conversion whatever the interrupt mode.
// - with the gain stage enabled, any gain setting lengthens conversion latency by exactly one converter clock.
// - writes to unimplemented fields or registers act as writes to a reserved address.
// - the half-gain code in the channel gain field is ignored.
// - the half-supply reference code is ignored.
// - the internal-ground negative input code is ignored.
// - the scan register does not exist and no channel sequencing happens.
// - the current limit field of the second control register does nothing.
// - the gain impedance mode bit of the second control register does nothing.
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
module adcq_top #(
  parameter int PRESCALE = adcq_pkg::ADC_PRESCALE,
  parameter int BASE_LAT = adcq_pkg::ADC_BASE_LAT
) (
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  // register port
  input  wire logic [adcq_pkg::ADDR_W-1:0]   addr,
  input  wire logic [adcq_pkg::DATA_W-1:0]   wr_data,
  input  wire logic                          wr_en,
  input  wire logic                          rd_en,
  output logic      [adcq_pkg::DATA_W-1:0]   rd_data,
  // event system
  input  wire logic                          event_start,
  output logic                               conv_event,
  // interrupt
  output logic                               irq,
  // converter front end
  input  wire logic [adcq_pkg::RES_W-1:0]    analog_code,
  output logic      [adcq_pkg::MUX_W-1:0]    mux_pos,
  output logic      [adcq_pkg::MUX_W-1:0]    mux_neg,
  output logic      [adcq_pkg::GAIN_W-1:0]   gain_sel,
  output logic                               gain_stage_en,
  output logic      [adcq_pkg::REF_W-1:0]    ref_sel,
  output logic                               conv_busy
);
  localparam int LAT_CYC      = PRESCALE * BASE_LAT;
  localparam int LAT_GAIN_CYC = PRESCALE * (BASE_LAT + adcq_pkg::GAIN_EXTRA);
  localparam int CW           = $clog2(LAT_GAIN_CYC + 2);

  adcq_pkg::adcq_state_type state;
  adcq_pkg::adcq_state_type next_state;

  logic                         enable;
  logic                         freerun;
  logic                         signed_mode;
  logic [adcq_pkg::IMODE_W-1:0] imode;
  logic [adcq_pkg::RES_W-1:0]   threshold;
  logic [adcq_pkg::RES_W-1:0]   result;
  logic [adcq_pkg::RES_W-1:0]   next_result;
  logic [adcq_pkg::RES_W-1:0]   code_bad;
  logic [adcq_pkg::STAT_W-1:0]  status;
  logic [adcq_pkg::STAT_W-1:0]  next_status;
  logic [adcq_pkg::STAT_W-1:0]  stat_set;
  logic [adcq_pkg::STAT_W-1:0]  stat_clr;
  logic [adcq_pkg::STAT_W-1:0]  mask;
  logic [adcq_pkg::DATA_W-1:0]  rd_value;
  logic                         sw_start;
  logic                         launch;
  logic                         conv_done;
  logic                         conv_single;
  logic                         conv_gain;
  logic                         below;
  logic                         above;
  logic                         cmp_hit;
  logic [CW-1:0]                cyc_cnt;

  // decode helpers
  logic wr_ctrl;
  logic wr_chan;
  assign wr_ctrl  = wr_en && (addr == adcq_pkg::CTRL_OFS);
  assign wr_chan  = wr_en && (addr == adcq_pkg::CHAN_OFS);
  assign sw_start = wr_ctrl && wr_data[adcq_pkg::CTRL_START_BIT];
  assign code_bad = analog_code ^ adcq_pkg::GAIN_SINGLE_CORRUPT;

  // start sources; free-running restarts whenever idle and enabled
  assign launch = enable && (state == adcq_pkg::ST_IDLE)
                  && (sw_start || event_start || freerun);

  adcq_conv_timer #(
    .PRESCALE (PRESCALE),
    .BASE_LAT (BASE_LAT)
  ) u_timer (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .start     (launch),
    .gain_used (gain_stage_en),
    .done      (conv_done)
  );

  always_comb
  begin
    next_state = state;
    case (state)
      adcq_pkg::ST_IDLE: if (launch) next_state = adcq_pkg::ST_CONV;
      adcq_pkg::ST_CONV: if (conv_done) next_state = adcq_pkg::ST_IDLE;
      default:           next_state = adcq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state     <= adcq_pkg::ST_IDLE;
      conv_busy <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      conv_busy <= (next_state == adcq_pkg::ST_CONV);
    end
  end

  // main control
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      enable      <= 1'b0;
      freerun     <= 1'b0;
      signed_mode <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      enable      <= wr_data[adcq_pkg::CTRL_EN_BIT];
      freerun     <= wr_data[adcq_pkg::CTRL_FREERUN_BIT];
      signed_mode <= wr_data[adcq_pkg::CTRL_SIGNED_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      ref_sel <= adcq_pkg::REF_RST;
    else if (wr_en && (addr == adcq_pkg::REFCTL_OFS)
             && (wr_data[adcq_pkg::REF_W-1:0] != adcq_pkg::REF_HALF_SUPPLY))
      ref_sel <= wr_data[adcq_pkg::REF_W-1:0];
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      gain_sel      <= adcq_pkg::GAIN_RST;
      gain_stage_en <= 1'b0;
    end
    else if (wr_chan)
    begin
      gain_stage_en <= wr_data[adcq_pkg::CHAN_GEN_BIT];
      if (wr_data[adcq_pkg::GAIN_W-1:0] != adcq_pkg::GAIN_HALF)
        gain_sel <= wr_data[adcq_pkg::GAIN_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      mux_pos <= adcq_pkg::MUX_RST;
      mux_neg <= adcq_pkg::MUX_RST;
    end
    else if (wr_en && (addr == adcq_pkg::MUXCTL_OFS))
    begin
      mux_pos <= wr_data[adcq_pkg::MUX_W-1:0];
      if (wr_data[adcq_pkg::MUX_NEG_LSB +: adcq_pkg::MUX_W] != adcq_pkg::NEG_INT_GND)
        mux_neg <= wr_data[adcq_pkg::MUX_NEG_LSB +: adcq_pkg::MUX_W];
    end
  end

  // compare setup and mask
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      imode     <= adcq_pkg::IMODE_COMPLETE;
      threshold <= adcq_pkg::RES_RST;
      mask      <= adcq_pkg::STAT_RST;
    end
    else if (wr_en)
    begin
      if (addr == adcq_pkg::INTCTL_OFS)
        imode <= wr_data[adcq_pkg::IMODE_W-1:0];
      if (addr == adcq_pkg::THRESH_OFS)
        threshold <= wr_data[adcq_pkg::RES_W-1:0];
      if (addr == adcq_pkg::MASK_OFS)
        mask <= wr_data[adcq_pkg::STAT_W-1:0];
    end
  end

  // how the running conversion was started
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      conv_single <= 1'b0;
      conv_gain   <= 1'b0;
    end
    else if (launch)
    begin
      conv_single <= !freerun;
      conv_gain   <= gain_stage_en;
    end
  end

  assign next_result = (conv_gain && conv_single) ? code_bad : analog_code;

  assign below = signed_mode ? ($signed(next_result) < $signed(threshold))
                             : (next_result < threshold);
  assign above = signed_mode ? ($signed(next_result) > $signed(threshold))
                             : (next_result > threshold);

  // compare flag from threshold condition only
  assign cmp_hit = conv_done && (((imode == adcq_pkg::IMODE_BELOW) && below)
                              || ((imode == adcq_pkg::IMODE_ABOVE) && above));

  always_comb
  begin
    stat_set = '0;
    stat_set[adcq_pkg::STAT_DONE_BIT] = conv_done;
    stat_set[adcq_pkg::STAT_CMP_BIT]  = cmp_hit;
    stat_clr = '0;
    if (wr_en && (addr == adcq_pkg::STATUS_OFS))
      stat_clr = wr_data[adcq_pkg::STAT_W-1:0];
    // set wins over clear
    next_status = (status & ~stat_clr) | stat_set;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      result <= adcq_pkg::RES_RST;
      status <= adcq_pkg::STAT_RST;
      irq    <= 1'b0;
    end
    else
    begin
      if (conv_done)
        result <= next_result;
      status <= next_status;
      irq    <= |(next_status & mask);
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      conv_event <= 1'b0;
    else
      conv_event <= conv_done;
  end

  // reserved and unimplemented locations read zero
  always_comb
  begin
    rd_value = '0;
    case (addr)
      adcq_pkg::CTRL_OFS:
      begin
        rd_value[adcq_pkg::CTRL_EN_BIT]      = enable;
        rd_value[adcq_pkg::CTRL_FREERUN_BIT] = freerun;
        rd_value[adcq_pkg::CTRL_SIGNED_BIT]  = signed_mode;
      end
      adcq_pkg::REFCTL_OFS: rd_value[adcq_pkg::REF_W-1:0] = ref_sel;
      adcq_pkg::CHAN_OFS:
      begin
        rd_value[adcq_pkg::GAIN_W-1:0]   = gain_sel;
        rd_value[adcq_pkg::CHAN_GEN_BIT] = gain_stage_en;
      end
      adcq_pkg::MUXCTL_OFS:
      begin
        rd_value[adcq_pkg::MUX_W-1:0]                      = mux_pos;
        rd_value[adcq_pkg::MUX_NEG_LSB +: adcq_pkg::MUX_W] = mux_neg;
      end
      adcq_pkg::INTCTL_OFS: rd_value[adcq_pkg::IMODE_W-1:0] = imode;
      adcq_pkg::THRESH_OFS: rd_value[adcq_pkg::RES_W-1:0]   = threshold;
      adcq_pkg::RESULT_OFS: rd_value[adcq_pkg::RES_W-1:0]   = result;
      adcq_pkg::STATUS_OFS: rd_value[adcq_pkg::STAT_W-1:0]  = status;
      adcq_pkg::MASK_OFS:   rd_value[adcq_pkg::STAT_W-1:0]  = mask;
      adcq_pkg::CTRL2_OFS:  rd_value = '0;
      default:              rd_value = '0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rd_data <= '0;
    else if (rd_en)
      rd_data <= rd_value;
    else
      rd_data <= '0;
  end

  // cycles spent converting, for latency checks
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      cyc_cnt <= '0;
    else if (launch)
      cyc_cnt <= '0;
    else if (state == adcq_pkg::ST_CONV)
      cyc_cnt <= CW'(cyc_cnt + 1'b1);
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_wr_half_gain;
    wr_chan && (wr_data[adcq_pkg::GAIN_W-1:0] == adcq_pkg::GAIN_HALF);
  endsequence
  sequence s_wr_half_ref;
    wr_en && (addr == adcq_pkg::REFCTL_OFS)
    && (wr_data[adcq_pkg::REF_W-1:0] == adcq_pkg::REF_HALF_SUPPLY);
  endsequence
  sequence s_wr_gnd_neg;
    wr_en && (addr == adcq_pkg::MUXCTL_OFS)
    && (wr_data[adcq_pkg::MUX_NEG_LSB +: adcq_pkg::MUX_W] == adcq_pkg::NEG_INT_GND);
  endsequence
  sequence s_single_gain_done;
    conv_done && conv_gain && conv_single;
  endsequence

  AST_GAIN_SINGLE_BAD: assert property (s_single_gain_done |=> result == $past(code_bad))
    else $error("gain single conversion result not corrupted");
  AST_EVENT_EVERY: assert property (conv_done |=> conv_event)
    else $error("event missing after completed conversion");
  AST_EVENT_ONLY: assert property (conv_event |-> $past(conv_done))
    else $error("event without completed conversion");
  AST_GAIN_LATENCY: assert property (conv_done |-> cyc_cnt == CW'(conv_gain ? LAT_GAIN_CYC : LAT_CYC))
    else $error("conversion latency wrong");
  AST_CTRL2_ZERO: assert property (rd_en && (addr == adcq_pkg::CTRL2_OFS) |=> rd_data == '0)
    else $error("second control register not reading zero");
  AST_GAIN_IMPEDANCE_MODE_IGNORED: assert property (wr_en && (addr == adcq_pkg::CTRL2_OFS) |=> $stable(gain_sel) && $stable(gain_stage_en))
    else $error("impedance mode write changed gain state");
  AST_HALF_GAIN: assert property (s_wr_half_gain |=> gain_sel == $past(gain_sel))
    else $error("half gain code accepted");
  AST_HALF_REF: assert property (s_wr_half_ref |=> $stable(ref_sel))
    else $error("half supply reference accepted");
  AST_GND_NEG: assert property (s_wr_gnd_neg |=> $stable(mux_neg))
    else $error("internal ground negative input accepted");
  AST_SCAN_ABSENT: assert property (rd_en && (addr == adcq_pkg::SCAN_OFS) |=> rd_data == '0)
    else $error("scan register read nonzero");
  AST_RESERVED_WR: assert property (wr_en && (addr == adcq_pkg::SCAN_OFS) |=> $stable(mux_pos) && $stable(enable) && $stable(imode))
    else $error("reserved write changed state");
  AST_CMP_CAUSE: assert property ($rose(status[adcq_pkg::STAT_CMP_BIT]) |-> $past(cmp_hit))
    else $error("compare flag set without threshold match");
  AST_CMP_MODE: assert property (conv_done && (imode == adcq_pkg::IMODE_COMPLETE) && !status[adcq_pkg::STAT_CMP_BIT] |=> !status[adcq_pkg::STAT_CMP_BIT])
    else $error("compare hit in completion mode");

endmodule

// ### adcq_pkg.sv
package adcq_pkg;

  // bus and result widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RES_W  = 12;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS     = 8'h00;
  localparam logic [ADDR_W-1:0] REFCTL_OFS   = 8'h04;
  localparam logic [ADDR_W-1:0] CHAN_OFS     = 8'h08;
  localparam logic [ADDR_W-1:0] MUXCTL_OFS   = 8'h0c;
  localparam logic [ADDR_W-1:0] INTCTL_OFS   = 8'h10;
  localparam logic [ADDR_W-1:0] THRESH_OFS   = 8'h14;
  localparam logic [ADDR_W-1:0] RESULT_OFS   = 8'h18;
  localparam logic [ADDR_W-1:0] STATUS_OFS   = 8'h1c;
  localparam logic [ADDR_W-1:0] MASK_OFS     = 8'h20;
  localparam logic [ADDR_W-1:0] CTRL2_OFS    = 8'h24;
  localparam logic [ADDR_W-1:0] SCAN_OFS     = 8'h28;

  // main control fields
  localparam int CTRL_EN_BIT      = 0;
  localparam int CTRL_START_BIT   = 1;
  localparam int CTRL_FREERUN_BIT = 2;
  localparam int CTRL_SIGNED_BIT  = 3;

  // reference select field
  localparam int               REF_W           = 3;
  localparam logic [REF_W-1:0] REF_RST         = 3'h0;
  localparam logic [REF_W-1:0] REF_HALF_SUPPLY = 3'h1;

  // channel control: gain code 0..6 is 1x..64x
  localparam int                GAIN_W       = 3;
  localparam logic [GAIN_W-1:0] GAIN_RST     = 3'h0;
  localparam logic [GAIN_W-1:0] GAIN_HALF    = 3'h7;
  localparam int                CHAN_GEN_BIT = 3;

  // input mux fields
  localparam int               MUX_W       = 4;
  localparam int               MUX_NEG_LSB = 4;
  localparam logic [MUX_W-1:0] MUX_RST     = 4'h0;
  localparam logic [MUX_W-1:0] NEG_INT_GND = 4'h7;

  // interrupt mode select
  localparam int                 IMODE_W        = 2;
  localparam logic [IMODE_W-1:0] IMODE_COMPLETE = 2'h0;
  localparam logic [IMODE_W-1:0] IMODE_BELOW    = 2'h1;
  localparam logic [IMODE_W-1:0] IMODE_ABOVE    = 2'h2;

  // status and mask layout
  localparam int               STAT_W        = 2;
  localparam int               STAT_DONE_BIT = 0;
  localparam int               STAT_CMP_BIT  = 1;
  localparam logic [STAT_W-1:0] STAT_RST     = 2'h0;

  // defect pattern on gain-stage single conversions
  localparam logic [RES_W-1:0] GAIN_SINGLE_CORRUPT = 12'ha5a;
  localparam logic [RES_W-1:0] RES_RST             = 12'h000;

  // conversion timing: prescale in reference clocks, latency in converter clocks
  localparam int ADC_PRESCALE = 4;
  localparam int ADC_BASE_LAT = 7;
  localparam int GAIN_EXTRA   = 1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } adcq_state_type;

endpackage

// ### adcq_conv_timer.sv
`timescale 1ns/1ps
module adcq_conv_timer #(
  parameter int PRESCALE = adcq_pkg::ADC_PRESCALE,
  parameter int BASE_LAT = adcq_pkg::ADC_BASE_LAT
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // control
  input  wire logic start,
  input  wire logic gain_used,
  output logic      done
);
  localparam int PW = $clog2(PRESCALE + 1);
  localparam int LW = $clog2(BASE_LAT + adcq_pkg::GAIN_EXTRA + 1);

  logic [PW-1:0] pre_cnt;
  logic [LW-1:0] tick_cnt;
  logic [LW-1:0] lat_target;
  logic          running;
  logic          tick;

  // converter clock enable, phase restarted at each start
  assign tick = running && (pre_cnt == PW'(PRESCALE - 1));

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pre_cnt    <= '0;
      tick_cnt   <= '0;
      lat_target <= '0;
      running    <= 1'b0;
      done       <= 1'b0;
    end
    else if (start)
    begin
      pre_cnt    <= '0;
      tick_cnt   <= '0;
      lat_target <= gain_used ? LW'(BASE_LAT + adcq_pkg::GAIN_EXTRA) : LW'(BASE_LAT);
      running    <= 1'b1;
      done       <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (running)
      begin
        pre_cnt <= tick ? '0 : PW'(pre_cnt + 1'b1);
        if (tick)
        begin
          if (tick_cnt == LW'(lat_target - 1'b1))
          begin
            running <= 1'b0;
            done    <= 1'b1;
          end
          else
          begin
            tick_cnt <= LW'(tick_cnt + 1'b1);
          end
        end
      end
    end
  end

endmodule

// ### adcq_front_model.sv
`timescale 1ns/1ps
module adcq_front_model (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // front end control
  input  wire logic [adcq_pkg::MUX_W-1:0] mux_pos,
  input  wire logic [adcq_pkg::MUX_W-1:0] mux_neg,
  input  wire logic                       gain_stage_en,
  input  wire logic                       conv_event,
  // sampled code
  output logic      [adcq_pkg::RES_W-1:0] analog_code
);
  logic [adcq_pkg::MUX_W-1:0] last_pos;
  logic [1:0]                 settle_cnt;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      last_pos   <= 4'h0;
      settle_cnt <= 2'h0;
    end
    else
    begin
      last_pos <= mux_pos;
      if (gain_stage_en && mux_pos != last_pos)
      begin
        settle_cnt <= 2'h3;
      end
      else if (conv_event && settle_cnt != 2'h0)
      begin
        settle_cnt <= settle_cnt - 2'h1;
      end
    end
  end

  // code follows the channel; spoilt while settling
  assign analog_code = {mux_pos, mux_neg, 4'h6} ^ ((settle_cnt != 2'h0) ? 12'h0ff : 12'h000);
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
  localparam int          PS    = 2;
  localparam int          BL    = 2;
  // completion is registered once more before busy drops
  localparam int          LAT   = PS * BL + 1;
  localparam int          GLAT  = PS * (BL + 1) + 1;
  localparam logic [11:0] CODE2 = 12'h256;

  logic        ref_clk;
  logic        rst;
  logic [7:0]  addr;
  logic [31:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rd_data;
  logic        event_start;
  logic        conv_event;
  logic        irq;
  logic [11:0] analog_code;
  logic [3:0]  mux_pos;
  logic [3:0]  mux_neg;
  logic [2:0]  gain_sel;
  logic        gain_stage_en;
  logic [2:0]  ref_sel;
  logic        conv_busy;
  logic [31:0] rv;
  int          n;
  int          error_cnt;
  int          checked;
  int          im [5] = '{0, 1, 1, 2, 2};
  int          th [5] = '{'h100, 'h300, 'h100, 'h100, 'h300};
  int          cm [5] = '{0, 1, 0, 1, 0};

  adcq_top #(.PRESCALE(PS), .BASE_LAT(BL)) adcq_top_inst (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .addr          (addr),
    .wr_data       (wr_data),
    .wr_en         (wr_en),
    .rd_en         (rd_en),
    .rd_data       (rd_data),
    .event_start   (event_start),
    .conv_event    (conv_event),
    .irq           (irq),
    .analog_code   (analog_code),
    .mux_pos       (mux_pos),
    .mux_neg       (mux_neg),
    .gain_sel      (gain_sel),
    .gain_stage_en (gain_stage_en),
    .ref_sel       (ref_sel),
    .conv_busy     (conv_busy)
  );

  adcq_front_model adcq_front_model_inst (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .mux_pos       (mux_pos),
    .mux_neg       (mux_neg),
    .gain_stage_en (gain_stage_en),
    .conv_event    (conv_event),
    .analog_code   (analog_code)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    rv = rd_data;
    chk(rv, exp);
  endtask

  // launch already taken: count cycles to completion, then the event pulse
  task automatic conv(input int lat);
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    while (conv_busy !== 1'b0 && n < 200);
    chk(n, lat);
    chk(conv_event, 1'b1);
  endtask

  task automatic wait_evt();
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    while (conv_event !== 1'b1 && n < 200);
  endtask

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #100000;
    error_cnt++;
    test_done();
  end

  initial
  begin
    rst         = 1'b1;
    addr        = 8'h00;
    wr_data     = 32'h0;
    wr_en       = 1'b0;
    rd_en       = 1'b0;
    event_start = 1'b0;
    error_cnt   = 0;
    checked     = 0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    chk({mux_pos, mux_neg, gain_sel, gain_stage_en, ref_sel, conv_busy, irq, conv_event}, 32'h0);
    for (int i = 0; i < 11; i++)
      rchk(8'(i * 4), 32'h0);
    end_test("reset");

    wr(adcq_pkg::CHAN_OFS, 32'h0b);
    wr(adcq_pkg::CHAN_OFS, 32'h07);
    wr(adcq_pkg::REFCTL_OFS, 32'h02);
    wr(adcq_pkg::REFCTL_OFS, 32'h01);
    wr(adcq_pkg::MUXCTL_OFS, 32'h59);
    wr(adcq_pkg::MUXCTL_OFS, 32'h72);
    wr(adcq_pkg::CTRL2_OFS, 32'hffff_ffff);
    wr(adcq_pkg::SCAN_OFS, 32'hffff_ffff);
    wr(8'h40, 32'hffff_ffff);
    chk({gain_sel, gain_stage_en}, 32'h6);
    chk(ref_sel, 32'h2);
    chk({mux_neg, mux_pos}, 32'h52);
    rchk(adcq_pkg::CHAN_OFS, 32'h03);
    rchk(adcq_pkg::REFCTL_OFS, 32'h02);
    rchk(adcq_pkg::MUXCTL_OFS, 32'h52);
    rchk(adcq_pkg::CTRL2_OFS, 32'h0);
    rchk(adcq_pkg::SCAN_OFS, 32'h0);
    rchk(8'h40, 32'h0);
    chk(conv_busy, 1'b0);
    end_test("options");

    wr(adcq_pkg::MASK_OFS, 32'h2);
    wr(adcq_pkg::CTRL_OFS, 32'h09);
    for (int i = 0; i < 5; i++)
    begin
      wr(adcq_pkg::STATUS_OFS, 32'h3);
      wr(adcq_pkg::INTCTL_OFS, im[i]);
      wr(adcq_pkg::THRESH_OFS, th[i]);
      wr(adcq_pkg::CTRL_OFS, 32'h0b);
      conv(LAT);
      chk(irq, cm[i]);
      rchk(adcq_pkg::RESULT_OFS, CODE2);
      rchk(adcq_pkg::STATUS_OFS, cm[i] * 2 + 1);
    end
    wr(adcq_pkg::MASK_OFS, 32'h1);
    @(posedge ref_clk);
    #1;
    chk(irq, 1'b1);
    wr(adcq_pkg::MASK_OFS, 32'h0);
    @(posedge ref_clk);
    #1;
    chk(irq, 1'b0);
    wr(adcq_pkg::MASK_OFS, 32'h1);
    wr(adcq_pkg::STATUS_OFS, 32'h1);
    #1;
    chk(irq, 1'b0);
    rchk(adcq_pkg::STATUS_OFS, 32'h0);
    end_test("compare");

    for (int g = 0; g < 7; g++)
    begin
      wr(adcq_pkg::CHAN_OFS, 32'h8 | g);
      #1;
      chk(gain_sel, g);
      wr(adcq_pkg::CTRL_OFS, 32'h0b);
      conv(GLAT);
      rchk(adcq_pkg::RESULT_OFS, CODE2 ^ adcq_pkg::GAIN_SINGLE_CORRUPT);
    end
    @(posedge ref_clk);
    event_start <= 1'b1;
    @(posedge ref_clk);
    event_start <= 1'b0;
    conv(GLAT);
    rchk(adcq_pkg::RESULT_OFS, CODE2 ^ adcq_pkg::GAIN_SINGLE_CORRUPT);
    end_test("gain single");

    wr(adcq_pkg::MUXCTL_OFS, 32'h53);
    wr(adcq_pkg::CTRL_OFS, 32'h0d);
    repeat (4) wait_evt();
    rchk(adcq_pkg::RESULT_OFS, 32'h356);
    wr(adcq_pkg::CTRL_OFS, 32'h09);
    repeat (2 * GLAT + 4) @(posedge ref_clk);
    #1;
    chk(conv_busy, 1'b0);
    end_test("freerun");
    test_done();
  end
endmodule
